//--- pkg/sgp_map.svh
// Register map, field values and counts of the shared-pin I/O port.
// Assumes inclusion by its bare name from the design files.
//
// Notes on behaviour
// - Enable bits 7..2 gate analog pins 7..2
// - Enable bit1 negative ref, bit0 positive ref
// - Enable one connects digital I/O to pin
// - Enable zero leaves pin digital-free, reset zero
// - Direction zero output (default), one input
// - Output bit reads back stored register value
// - Input bit write only stores, never drives
// - Enable register 8-bit RW at 0Ch, reset 00h
// - Direction register 8-bit RW at 0Dh, reset 00h
// - Data register 8-bit RW at 0Eh, reset 00h
// - Serial link runs SPI mode 1 both sides
// - Clock idles low, data launched on rising
// - Both sides sample data on falling edges
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// ==========================================================
// Register indices and byte addresses
`define SGP_IDX_ENABLE 4'hC
`define SGP_IDX_DIR 4'hD
`define SGP_IDX_LEVEL 4'hE
`define SGP_IDX_STATUS 4'hF
`define SGP_ADDR_ENABLE {`SGP_IDX_ENABLE, 2'h0}
`define SGP_ADDR_DIR {`SGP_IDX_DIR, 2'h0}
`define SGP_ADDR_LEVEL {`SGP_IDX_LEVEL, 2'h0}
`define SGP_ADDR_STATUS {`SGP_IDX_STATUS, 2'h0}
`define SGP_IDX_GROUP 2'h3

// ==========================================================
// Reset values and bus answers
`define SGP_RST_BYTE 8'h00
`define SGP_RST_WORD 32'h0000_0000
`define SGP_SYNC_RST 9'h100
`define SGP_RESP_OK 2'h0
`define SGP_RESP_SLVERR 2'h2

// ==========================================================
// Serial frame layout
`define SGP_CS_BIT 8
`define SGP_CMD_RD_BIT 7
`define SGP_CNT_ZERO 5'h00
`define SGP_CNT_CMD 5'h07
`define SGP_CNT_DATA 5'h08
`define SGP_CNT_LAST 5'h0F
`define SGP_CNT_OVER 5'h10
`define SGP_CNT_MAX 5'h1F

`endif

//--- pkg/sgp_pkg.sv
// Types shared by the shared-pin I/O port modules.
// Assumes sgp_map.svh is on the include path.
package sgp_pkg;

	// ==========================================================
	// Basic types
	typedef logic [7:0] sgp_byte_t;
	typedef logic [8:0] sgp_sync_vec_t;

	typedef enum logic [1:0] {
		SGP_BUS_IDLE = 2'h0,
		SGP_BUS_ANSWER = 2'h1
	} sgp_bus_state_t;

	// ==========================================================
	// State records
	typedef struct packed {
		sgp_sync_vec_t s1;
		sgp_sync_vec_t s2;
		sgp_sync_vec_t s3;
		sgp_sync_vec_t val;
	} sgp_sync_t;

	typedef struct packed {
		logic [4:0] count;
		sgp_byte_t shift;
		sgp_byte_t cmd;
	} sgp_rx_t;

	typedef struct packed {
		logic ok;
		logic rd;
		logic [3:0] idx;
		sgp_byte_t data;
	} sgp_frame_t;

	typedef struct packed {
		sgp_byte_t shift;
		logic miso;
		logic oe;
	} sgp_tx_t;

	typedef struct packed {
		sgp_bus_state_t bus;
		logic wait_n;
		logic [31:0] rdata;
		logic [1:0] resp;
		sgp_byte_t pin_en;
		sgp_byte_t dir;
		sgp_byte_t level;
		sgp_byte_t frames;
		sgp_byte_t pin_out;
		sgp_byte_t pin_oe;
		sgp_byte_t claim;
		logic [31:0] snap;
		logic cs_prev;
	} sgp_top_t;

endpackage

//--- design/sgp_in_sync.sv
// Three-stage synchroniser for pins and the frame select.
// Assumes inputs asynchronous to clk_i; a change counts once stages two and three agree.
`timescale 1ns/10ps
`include "sgp_map.svh"
module sgp_in_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire sgp_pkg::sgp_sync_vec_t raw_i,
	output sgp_pkg::sgp_sync_vec_t val_o
);
	import sgp_pkg::*;

	sgp_sync_t st_q;
	sgp_sync_t st_d;
	sgp_sync_vec_t agreed;

	// ==========================================================
	// Per-bit agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++) begin : g_bit
			assign agreed[gi] = (st_q.s2[gi] == st_q.s3[gi]) ? st_q.s3[gi] : st_q.val[gi];
		end
	endgenerate

	always_comb begin
		st_d = st_q;
		st_d.s1 = raw_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.val = agreed;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= {`SGP_SYNC_RST, `SGP_SYNC_RST, `SGP_SYNC_RST, `SGP_SYNC_RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign val_o = st_q.val;
endmodule // sgp_in_sync

//--- design/sgp_spi_link.sv
// Serial link engine on the link clock: 16-bit frames, SPI mode 1.
// Assumes frame select high between frames and a frozen snapshot while it is low.
`timescale 1ns/10ps
`include "sgp_map.svh"
module sgp_spi_link (
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic [31:0] snap_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic frame_ok_o,
	output logic frame_rd_o,
	output logic [3:0] frame_idx_o,
	output sgp_pkg::sgp_byte_t frame_data_o
);
	import sgp_pkg::*;

	sgp_rx_t rx_q, rx_d;
	sgp_frame_t fr_q, fr_d;
	sgp_tx_t tx_q, tx_d;
	sgp_byte_t rx_byte;
	sgp_byte_t sel;

	// ==========================================================
	// Receive on falling edges
	always_comb begin
		rx_byte = {rx_q.shift[6:0], mosi_i};
		rx_d = rx_q;
		rx_d.shift = rx_byte;
		if (rx_q.count != `SGP_CNT_MAX) begin
			rx_d.count = rx_q.count + 5'h01;
		end
		if (rx_q.count == `SGP_CNT_CMD) begin
			rx_d.cmd = rx_byte;
		end
		fr_d = fr_q;
		if (rx_q.count == `SGP_CNT_ZERO) begin
			fr_d.ok = 1'b0;
		end else if (rx_q.count == `SGP_CNT_LAST) begin
			fr_d.ok = 1'b1;
			fr_d.rd = rx_q.cmd[`SGP_CMD_RD_BIT];
			fr_d.idx = rx_q.cmd[3:0];
			fr_d.data = rx_byte;
		end else if (rx_q.count == `SGP_CNT_OVER) begin
			fr_d.ok = 1'b0;
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rx_q <= '0;
		end else begin
			rx_q <= rx_d;
		end
	end

	always_ff @(negedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// ==========================================================
	// Transmit on rising edges
	always_comb begin
		sel = `SGP_RST_BYTE;
		if (rx_q.cmd[`SGP_CMD_RD_BIT] && (rx_q.cmd[3:2] == `SGP_IDX_GROUP)) begin
			sel = snap_i[{rx_q.cmd[1:0], 3'h0} +: 8];
		end
		tx_d = tx_q;
		tx_d.oe = 1'b1;
		if (rx_q.count == `SGP_CNT_DATA) begin
			tx_d.miso = sel[7];
			tx_d.shift = {sel[6:0], 1'b0};
		end else begin
			tx_d.miso = tx_q.shift[7];
			tx_d.shift = {tx_q.shift[6:0], 1'b0};
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign miso_o = tx_q.miso;
	assign miso_oe_o = tx_q.oe;
	assign frame_ok_o = fr_q.ok;
	assign frame_rd_o = fr_q.rd;
	assign frame_idx_o = fr_q.idx;
	assign frame_data_o = fr_q.data;
endmodule // sgp_spi_link

//--- design/sgp_top.sv
// Eight-bit shared-pin I/O port: Avalon-MM register slave, serial link, pin drive.
// Assumes pins and link signals are asynchronous to clk_i; the link clock idles low.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "sgp_map.svh"
module sgp_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire sgp_pkg::sgp_byte_t pin_in_i,
	output sgp_pkg::sgp_byte_t pin_out_o,
	output sgp_pkg::sgp_byte_t pin_oe_o,
	output sgp_pkg::sgp_byte_t digital_claim_o
);
	import sgp_pkg::*;

	// ==========================================================
	// Declarations
	sgp_top_t st_q;
	sgp_top_t st_d;
	sgp_sync_vec_t sync_val;
	logic cs_high;
	logic frame_ok;
	logic frame_rd;
	logic [3:0] frame_idx;
	sgp_byte_t frame_data;
	sgp_byte_t level_rd;
	sgp_byte_t drive_en;
	sgp_byte_t drive_lvl;
	logic bus_req;
	logic frame_end;
	logic spi_wr;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic be_low;

	// ==========================================================
	// Input synchronisers
	sgp_in_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i({spi_cs_n_i, pin_in_i}),
		.val_o(sync_val)
	);

	assign cs_high = sync_val[`SGP_CS_BIT];

	// ==========================================================
	// Serial link engine
	sgp_spi_link u_link (
		.rst_i(rst_i),
		.sclk_i(spi_sclk_i),
		.cs_n_i(spi_cs_n_i),
		.mosi_i(spi_mosi_i),
		.snap_i(st_q.snap),
		.miso_o(spi_miso_o),
		.miso_oe_o(spi_miso_oe_o),
		.frame_ok_o(frame_ok),
		.frame_rd_o(frame_rd),
		.frame_idx_o(frame_idx),
		.frame_data_o(frame_data)
	);

	// ==========================================================
	// Per-pin readback and drive
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			// bit gi serves the shared pin of the same index
			assign drive_en[gi] = st_q.pin_en[gi] & ~st_q.dir[gi];
			assign drive_lvl[gi] = drive_en[gi] & st_q.level[gi];
			assign level_rd[gi] = (st_q.pin_en[gi] & st_q.dir[gi]) ?
				sync_val[gi] : st_q.level[gi];
		end
	endgenerate

	// ==========================================================
	// Frame completion and bus request
	assign frame_end = cs_high & ~st_q.cs_prev;
	assign spi_wr = frame_end & frame_ok & ~frame_rd;
	assign bus_req = avs_read_i | avs_write_i;
	assign be_low = avs_byteenable_i[0];

	// ==========================================================
	// Read decode
	always_comb begin
		rd_word = `SGP_RST_WORD;
		rd_resp = `SGP_RESP_OK;
		if (avs_address_i == `SGP_ADDR_ENABLE) begin
			rd_word = {24'h000000, st_q.pin_en};
		end else if (avs_address_i == `SGP_ADDR_DIR) begin
			rd_word = {24'h000000, st_q.dir};
		end else if (avs_address_i == `SGP_ADDR_LEVEL) begin
			rd_word = {24'h000000, level_rd};
		end else if (avs_address_i == `SGP_ADDR_STATUS) begin
			rd_word = {24'h000000, st_q.frames};
		end else begin
			rd_resp = `SGP_RESP_SLVERR;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.cs_prev = cs_high;

		// Snapshot for the link, frozen while a frame runs
		if (cs_high) begin
			st_d.snap = {st_q.frames, level_rd, st_q.dir, st_q.pin_en};
		end

		// Frame count and writes arriving over the link
		if (frame_end && frame_ok) begin
			st_d.frames = st_q.frames + 8'h01;
		end
		if (spi_wr) begin
			if (frame_idx == `SGP_IDX_ENABLE) begin
				st_d.pin_en = frame_data;
			end else if (frame_idx == `SGP_IDX_DIR) begin
				st_d.dir = frame_data;
			end else if (frame_idx == `SGP_IDX_LEVEL) begin
				st_d.level = frame_data;
			end
		end

		// Avalon slave, one wait cycle then answer
		case (st_q.bus)
			SGP_BUS_IDLE: begin
				if (bus_req) begin
					st_d.bus = SGP_BUS_ANSWER;
					st_d.wait_n = 1'b1;
					st_d.resp = rd_resp;
					st_d.rdata = avs_read_i ? rd_word : `SGP_RST_WORD;
					if (avs_write_i && be_low) begin
						if (avs_address_i == `SGP_ADDR_ENABLE) begin
							st_d.pin_en = avs_writedata_i[7:0];
						end else if (avs_address_i == `SGP_ADDR_DIR) begin
							st_d.dir = avs_writedata_i[7:0];
						end else if (avs_address_i == `SGP_ADDR_LEVEL) begin
							st_d.level = avs_writedata_i[7:0];
						end
					end
				end
			end
			SGP_BUS_ANSWER: begin
				st_d.bus = SGP_BUS_IDLE;
				st_d.wait_n = 1'b0;
			end
			default: begin
				st_d.bus = SGP_BUS_IDLE;
				st_d.wait_n = 1'b0;
			end
		endcase

		// Pin drive follows the registers
		st_d.claim = st_q.pin_en;
		st_d.pin_oe = drive_en;
		st_d.pin_out = drive_lvl;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.bus <= SGP_BUS_IDLE;
			st_q.wait_n <= 1'b0;
			st_q.rdata <= `SGP_RST_WORD;
			st_q.resp <= `SGP_RESP_OK;
			st_q.pin_en <= `SGP_RST_BYTE;
			st_q.dir <= `SGP_RST_BYTE;
			st_q.level <= `SGP_RST_BYTE;
			st_q.frames <= `SGP_RST_BYTE;
			st_q.pin_out <= `SGP_RST_BYTE;
			st_q.pin_oe <= `SGP_RST_BYTE;
			st_q.claim <= `SGP_RST_BYTE;
			st_q.snap <= `SGP_RST_WORD;
			st_q.cs_prev <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	assign avs_readdata_o = st_q.rdata;
	assign avs_waitrequest_o = ~st_q.wait_n;
	assign avs_response_o = st_q.resp;
	assign pin_out_o = st_q.pin_out;
	assign pin_oe_o = st_q.pin_oe;
	assign digital_claim_o = st_q.claim;
endmodule // sgp_top

//--- test/sgp_properties.sv
// Concurrent checks on the ports of the shared-pin I/O port.
// Assumes binding to sgp_top; link signals are sampled on clk_i.
`timescale 1ns/10ps
module sgp_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe_o,
	input wire sgp_pkg::sgp_byte_t pin_oe_o,
	input wire sgp_pkg::sgp_byte_t pin_out_o,
	input wire sgp_pkg::sgp_byte_t digital_claim_o
);
	import sgp_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// Sequences
	sequence s_req;
		$rose(avs_read_i || avs_write_i);
	endsequence
	sequence s_take(a);
		s_req ##0 avs_address_i == a;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	// ====
	// Properties
	property p_reset;
		$fell(rst_i) |-> avs_waitrequest_o && digital_claim_o == 8'h00 && pin_oe_o == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared");
	property p_oe_claim;
		(pin_oe_o & ~digital_claim_o) == 8'h00;
	endproperty
	a_oe_claim: assert property (p_oe_claim) else $error("drive on idle pin");
	property p_out_oe;
		(pin_out_o & ~pin_oe_o) == 8'h00;
	endproperty
	a_out_oe: assert property (p_out_oe) else $error("level on undriven pin");
	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer too long");
	property p_answer;
		s_req |=> s_ans;
	endproperty
	a_answer: assert property (p_answer) else $error("answer missing");
	property p_unmapped;
		s_take(6'h00) ##0 avs_read_i |=> avs_response_o == 2'h2 && avs_readdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad unmapped answer");
	property p_claim;
		s_take(6'h30) ##0 avs_write_i && avs_byteenable_i[0]
			|-> ##3 digital_claim_o == $past(avs_writedata_i[7:0], 3);
	endproperty
	a_claim: assert property (p_claim) else $error("enable not applied");
	property p_link_idle;
		spi_cs_n_i && $past(spi_cs_n_i) |-> !spi_miso_oe_o && !spi_miso_o;
	endproperty
	a_link_idle: assert property (p_link_idle) else $error("link driven idle");
endmodule // sgp_properties

//--- test/sgp_spi_host.sv
// Host model: SPI mode 1 master on the port's serial link.
// Assumes frames are started by calling xfer; clock half period 6 ns.
`timescale 1ns/10ps
module sgp_spi_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		mosi_o = 1'b0;
		// One clean rising select edge clears the link engine
		#1 cs_n_o = 1'b1;
	end
	task automatic xfer(input logic [15:0] w, output logic [7:0] r);
		r = 8'h00;
		#3 cs_n_o = 1'b0;
		#44;
		for (int i = 15; i >= 0; i--) begin
			sclk_o = 1'b1;
			mosi_o = w[i];
			#6 sclk_o = 1'b0;
			if (i < 8) r = {r[6:0], miso_i};
			#6;
		end
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#70;
	endtask
endmodule // sgp_spi_host

//--- test/testbench.sv
// Self-checking bench of the shared-pin I/O port.
// Assumes sgp_pkg, sgp_top and the host model are compiled first.
`timescale 1ns/10ps
module testbench;
	import sgp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] avs_response_o;
	logic spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
	sgp_byte_t pin_in_i = 8'h00;
	sgp_byte_t pin_out_o, pin_oe_o, digital_claim_o;
	int error_cnt = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'd76816;
	always #4 clk_i = ~clk_i;
	sgp_top u_sgp_top (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.avs_response_o, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o,
		.spi_miso_oe_o, .pin_in_i, .pin_out_o, .pin_oe_o, .digital_claim_o);
	sgp_spi_host u_sgp_spi_host (.sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
		.mosi_o(spi_mosi_i), .miso_i(spi_miso_o));
	function logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] exp_rd(logic [7:0] en, dir, dat, pin);
		return (en & dir & pin) | (~(en & dir) & dat);
	endfunction
	task complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
			error_cnt++;
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			complete_run();
		end
		q = avs_readdata_o;
		r = avs_response_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	initial begin
		logic [31:0] q;
		logic [1:0] r;
		logic [7:0] en, dir, dat, lr;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 12; a < 16; a++) begin
			bus(1'b0, 6'(a * 4), 8'h00, q, r);
			chk(8'h00, q[7:0]);
		end
		bus(1'b0, 6'h00, 8'h00, q, r);
		chk(8'h02, {6'h0, r});
		$display("test reset done");
		for (int k = 0; k < 20; k++) begin
			en = rnd8();
			dir = rnd8();
			dat = rnd8();
			if (k < 2) begin
				en = 8'hFF;
				dir = {8{k[0]}};
			end
			pin_in_i <= rnd8();
			bus(1'b1, 6'h30, en, q, r);
			bus(1'b1, 6'h34, dir, q, r);
			bus(1'b1, 6'h38, dat, q, r);
			repeat (10) @(posedge clk_i);
			chk(en, digital_claim_o);
			chk(en & ~dir, pin_oe_o);
			chk(dat & en & ~dir, pin_out_o);
			bus(1'b0, 6'h34, 8'h00, q, r);
			chk(dir, q[7:0]);
			bus(1'b0, 6'h38, 8'h00, q, r);
			chk(exp_rd(en, dir, dat, pin_in_i), q[7:0]);
			chk(8'h00, {6'h0, r});
		end
		avs_byteenable_i <= 4'hE;
		bus(1'b1, 6'h30, ~en, q, r);
		avs_byteenable_i <= 4'hF;
		bus(1'b0, 6'h30, 8'h00, q, r);
		chk(en, q[7:0]);
		$display("test random done");
		bus(1'b1, 6'h34, 8'h00, q, r);
		bus(1'b1, 6'h30, 8'h5A, q, r);
		u_sgp_spi_host.xfer({8'h0E, 8'hC3}, lr);
		repeat (10) @(posedge clk_i);
		bus(1'b0, 6'h38, 8'h00, q, r);
		chk(8'hC3, q[7:0]);
		chk(8'h42, pin_out_o);
		u_sgp_spi_host.xfer({8'h8C, 8'h00}, lr);
		chk(8'h5A, lr);
		repeat (10) @(posedge clk_i);
		bus(1'b0, 6'h3C, 8'h00, q, r);
		chk(8'h02, q[7:0]);
		$display("test link done");
		complete_run();
	end
endmodule // testbench
bind sgp_top sgp_properties u_sgp_properties (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.avs_response_o, .spi_cs_n_i, .spi_miso_o, .spi_miso_oe_o, .pin_oe_o, .pin_out_o,
	.digital_claim_o);
